// ### lookup_pipeline_model.sv
// Purpose: pipeline side that issues control moves and table instructions
// Assumes: the bench calls issue once per rising edge, in its time step
// Notes:   payloads of idle ports are randomised by the caller each cycle
`timescale 1ns/1ps
module lookup_pipeline_model (
	input  wire logic                  clk,
	output table_ctrl_pkg::move_req_t  moveReq,
	output table_ctrl_pkg::table_req_t tableReq,
	output logic [1:0]                 roCfgTable,
	output logic                       roCfgWrite,
	output logic [63:0]                roCfgData
);
	// ------------------------------------------------------------------
	// request drive
	// ------------------------------------------------------------------
	// quiet ports at time zero so reset sees no request
	initial begin
		moveReq    = '0;
		tableReq   = '0;
		roCfgTable = 2'h0;
		roCfgWrite = 1'b0;
		roCfgData  = 64'h0000_0000_0000_0000;
	end

	// non-blocking so the block samples the old values at this edge
	task automatic issue(input table_ctrl_pkg::move_req_t m,
		input table_ctrl_pkg::table_req_t t, input logic ro,
		input logic [1:0] roT, input logic [63:0] roD);
		moveReq    <= m;
		tableReq   <= t;
		roCfgWrite <= ro;
		roCfgTable <= roT;
		roCfgData  <= roD;
	endtask
endmodule

// ### table_ctrl_map.svh
// Purpose: offsets, field positions and reset values of the table registers
// Assumes: control-register moves address registers by a small index
// Notes:   definitions only
`ifndef TABLE_CTRL_MAP_SVH
`define TABLE_CTRL_MAP_SVH

// ----------------------------------------------------------------------
// register indices on the control-move port
// ----------------------------------------------------------------------
`define TBL_IDX_BASE0      4'h0
`define TBL_IDX_BASE3      4'h3
`define TBL_IDX_CFG0       4'h4
`define TBL_IDX_CFG3       4'h7
`define TBL_IDX_PERM       4'h8

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BASE_ADDR_HI       15
`define BASE_ADDR_LO       7
`define CFG_LEGACY_BIT     28
`define CFG_WIDEN_HI       25
`define CFG_WIDEN_LO       24
`define CFG_SIZE_HI        23
`define CFG_SIZE_LO        16
`define CFG_WEIGHT_HI      13
`define CFG_WEIGHT_LO      11
`define CFG_INTERP_HI      10
`define CFG_INTERP_LO      8
`define CFG_CLAMP_BIT      7
`define CFG_SIGNED_BIT     6
`define CFG_ELEM_HI        5
`define CFG_ELEM_LO        3
`define CFG_PARALLEL_TABLE_COUNT_HI        2
`define CFG_PARALLEL_TABLE_COUNT_LO        0
`define PERM_STRIDE        4
`define FAULT_CAUSE_BIT    6

// ----------------------------------------------------------------------
// reset values, largest legal codes and the reserved table count code
// ----------------------------------------------------------------------
`define CFG_RESET          64'h0000_0000_0000_0000
`define PERM_RESET         2'h0
`define SIZE_CODE_MAX      8'h06
`define WEIGHT_CODE_MAX    3'h1
`define INTERP_CODE_MAX    3'h3
`define ELEM_CODE_MAX      3'h2
`define PARALLEL_TABLE_COUNT_CODE_MAX      3'h5
`define PARALLEL_TABLE_COUNT_CODE_GAP      3'h3

`endif

// ### table_ctrl_pkg.sv
// Purpose: types shared by the table control block
// Assumes: nothing
// Notes:   no constants here, see table_ctrl_map.svh
package table_ctrl_pkg;

	// permission codes per table set
	typedef enum logic [1:0] {
		PERM_NONE   = 2'b00,
		PERM_READ   = 2'b01,
		PERM_UPDATE = 2'b10,
		PERM_FULL   = 2'b11
	} perm_code_t;

	// table instruction kinds
	typedef enum logic [2:0] {
		OP_READ   = 3'b000,
		OP_WRITE  = 3'b001,
		OP_INIT   = 3'b010,
		OP_BIN    = 3'b011,
		OP_WBIN   = 3'b100
	} table_op_t;

	// control-register move request
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        supervisor;
		logic [3:0]  index;
		logic [63:0] data;
	} move_req_t;

	// table instruction request
	typedef struct packed {
		logic       valid;
		table_op_t  op;
		logic [1:0] tableIdx;
	} table_req_t;

	// decoded configuration of one table set
	typedef struct packed {
		logic       legacyBankLayout;
		logic [1:0] resultWidenMode;
		logic [7:0] sizeCode;
		logic [2:0] weightWidth;
		logic [2:0] interpolation;
		logic       binClampEnable;
		logic       signedElements;
		logic [2:0] elementWidth;
		logic [2:0] parallelTableCount;
	} table_cfg_t;

endpackage

// ### table_ctrl_regs.sv
// Purpose: base, configuration and permission registers for table lookup
// Assumes: one move or instruction request per cycle on each port
// Notes:   answers and faults are registered, one cycle after the request
`timescale 1ns/1ps
`include "table_ctrl_map.svh"

module table_ctrl_regs #(
	parameter int TABLES = 4
) (
	input  wire logic                      clk,
	input  wire logic                      reset_n,
	input  wire table_ctrl_pkg::move_req_t moveReq,
	input  wire table_ctrl_pkg::table_req_t tableReq,
	input  wire logic [1:0]                roCfgTable,
	input  wire logic                      roCfgWrite,
	input  wire logic [63:0]               roCfgData,
	output logic                           moveDone,
	output logic [63:0]                    moveReadData,
	output logic                           moveFault,
	output logic                           tableGo,
	output logic                           tableFault,
	output logic [63:0]                    faultReport,
	output table_ctrl_pkg::table_cfg_t     tableCfg [TABLES]
);

	// ------------------------------------------------------------------
	// storage
	// ------------------------------------------------------------------
	logic [8:0]  baseAddr [TABLES];
	logic [63:0] cfgWord  [TABLES];
	table_ctrl_pkg::perm_code_t permCode [TABLES];

	// ------------------------------------------------------------------
	// legalising decode, used for software and internal writes alike
	// ------------------------------------------------------------------
	function automatic logic [63:0] clean_cfg(input logic [63:0] w);
		logic [63:0] r;
		r = 64'h0000_0000_0000_0000;
		r[`CFG_LEGACY_BIT] = w[`CFG_LEGACY_BIT];
		r[`CFG_WIDEN_HI:`CFG_WIDEN_LO] =
			w[`CFG_WIDEN_HI:`CFG_WIDEN_LO];
		if (w[`CFG_SIZE_HI:`CFG_SIZE_LO] <= `SIZE_CODE_MAX)
			r[`CFG_SIZE_HI:`CFG_SIZE_LO] =
				w[`CFG_SIZE_HI:`CFG_SIZE_LO];
		if (w[`CFG_WEIGHT_HI:`CFG_WEIGHT_LO] <= `WEIGHT_CODE_MAX)
			r[`CFG_WEIGHT_HI:`CFG_WEIGHT_LO] =
				w[`CFG_WEIGHT_HI:`CFG_WEIGHT_LO];
		r[`CFG_CLAMP_BIT]  = w[`CFG_CLAMP_BIT];
		r[`CFG_SIGNED_BIT] = w[`CFG_SIGNED_BIT];
		r = clean_rw(r, w);
		return r;
	endfunction

	// writable fields only: software moves touch these and nothing else
	function automatic logic [63:0] clean_rw(input logic [63:0] keep,
			input logic [63:0] w);
		logic [63:0] r;
		r = keep;
		r[`CFG_INTERP_HI:`CFG_INTERP_LO] = 3'h0;
		r[`CFG_ELEM_HI:`CFG_ELEM_LO] = 3'h0;
		r[`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO] = 3'h0;
		r[`CFG_CLAMP_BIT]  = w[`CFG_CLAMP_BIT];
		r[`CFG_SIGNED_BIT] = w[`CFG_SIGNED_BIT];
		if (w[`CFG_INTERP_HI:`CFG_INTERP_LO] <= `INTERP_CODE_MAX)
			r[`CFG_INTERP_HI:`CFG_INTERP_LO] =
				w[`CFG_INTERP_HI:`CFG_INTERP_LO];
		if (w[`CFG_ELEM_HI:`CFG_ELEM_LO] <= `ELEM_CODE_MAX)
			r[`CFG_ELEM_HI:`CFG_ELEM_LO] =
				w[`CFG_ELEM_HI:`CFG_ELEM_LO];
		if (w[`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO] <= `PARALLEL_TABLE_COUNT_CODE_MAX &&
				w[`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO] != `PARALLEL_TABLE_COUNT_CODE_GAP)
			r[`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO] =
				w[`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO];
		return r;
	endfunction

	// ------------------------------------------------------------------
	// move decode
	// ------------------------------------------------------------------
	logic       moveIsBase;
	logic       moveIsCfg;
	logic       moveIsPerm;
	logic [1:0] moveTable;

	// index[1:0] picks the table for base and configuration moves; the
	// permission index lands on table 0 here but never uses that check
	always_comb begin
		moveIsBase = moveReq.index <= `TBL_IDX_BASE3;
		moveIsCfg  = moveReq.index >= `TBL_IDX_CFG0 &&
			moveReq.index <= `TBL_IDX_CFG3;
		moveIsPerm = moveReq.index == `TBL_IDX_PERM;
		moveTable  = moveReq.index[1:0];
	end

	// ------------------------------------------------------------------
	// permission checks, one for moves, one for instructions
	// ------------------------------------------------------------------
	logic moveGranted;
	logic opGranted;

	table_perm_check moveCheck (
		.code      (permCode[moveTable]),
		.isMove    (1'b1),
		.moveWrite (moveReq.write),
		.op        (table_ctrl_pkg::OP_READ),
		.granted   (moveGranted)
	);

	table_perm_check opCheck (
		.code      (permCode[tableReq.tableIdx]),
		.isMove    (1'b0),
		.moveWrite (1'b0),
		.op        (tableReq.op),
		.granted   (opGranted)
	);

	// the permission register itself needs supervisor mode to be written;
	// an unmapped index or a user write to it is a fault
	logic moveOk;

	always_comb begin
		if (moveIsPerm)
			moveOk = !moveReq.write || moveReq.supervisor;
		else if (moveIsBase || moveIsCfg)
			moveOk = moveGranted;
		else
			moveOk = 1'b0;
	end

	// ------------------------------------------------------------------
	// base address registers, no reset: content undefined after reset
	// ------------------------------------------------------------------
	// only bits 15-7 are stored: higher address bits of a move are
	// dropped, which saves flops since the table region is small
	always_ff @(posedge clk) begin
		if (moveReq.valid && moveReq.write && moveIsBase && moveOk)
			baseAddr[moveTable] <=
				moveReq.data[`BASE_ADDR_HI:`BASE_ADDR_LO];
	end

	// ------------------------------------------------------------------
	// configuration registers, one per table set
	// ------------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < TABLES; g++) begin : cfgSet
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					cfgWord[g] <= `CFG_RESET;
				else if (roCfgWrite && roCfgTable == 2'(g))
					cfgWord[g] <= clean_cfg(roCfgData);
				else if (moveReq.valid && moveReq.write && moveIsCfg &&
						moveOk && moveTable == 2'(g))
					cfgWord[g] <= clean_rw(cfgWord[g],
						moveReq.data);
			end

			always_comb begin
				tableCfg[g].legacyBankLayout = cfgWord[g][`CFG_LEGACY_BIT];
				tableCfg[g].resultWidenMode =
					cfgWord[g][`CFG_WIDEN_HI:`CFG_WIDEN_LO];
				tableCfg[g].sizeCode = cfgWord[g][`CFG_SIZE_HI:`CFG_SIZE_LO];
				tableCfg[g].weightWidth =
					cfgWord[g][`CFG_WEIGHT_HI:`CFG_WEIGHT_LO];
				tableCfg[g].interpolation =
					cfgWord[g][`CFG_INTERP_HI:`CFG_INTERP_LO];
				tableCfg[g].binClampEnable = cfgWord[g][`CFG_CLAMP_BIT];
				tableCfg[g].signedElements = cfgWord[g][`CFG_SIGNED_BIT];
				tableCfg[g].elementWidth =
					cfgWord[g][`CFG_ELEM_HI:`CFG_ELEM_LO];
				tableCfg[g].parallelTableCount =
					cfgWord[g][`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO];
			end

			// permission field per table, supervisor-only
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n)
					permCode[g] <= table_ctrl_pkg::PERM_NONE;
				else if (moveReq.valid && moveReq.write && moveIsPerm &&
						moveReq.supervisor)
					permCode[g] <= table_ctrl_pkg::perm_code_t'(
						moveReq.data[`PERM_STRIDE*g +: 2]);
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// move answer: read data and fault, one cycle after the request
	// ------------------------------------------------------------------
	logic [63:0] next_moveReadData;

	always_comb begin
		next_moveReadData = 64'h0000_0000_0000_0000;
		if (moveIsBase)
			next_moveReadData[`BASE_ADDR_HI:`BASE_ADDR_LO] =
				baseAddr[moveTable];
		else if (moveIsCfg)
			next_moveReadData = cfgWord[moveTable];
		else if (moveIsPerm)
			for (int i = 0; i < TABLES; i++)
				next_moveReadData[`PERM_STRIDE*i +: 2] = permCode[i];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			moveDone     <= 1'b0;
			moveFault    <= 1'b0;
			moveReadData <= 64'h0000_0000_0000_0000;
		end else begin
			moveDone  <= moveReq.valid && moveOk;
			moveFault <= moveReq.valid && !moveOk;
			if (moveReq.valid && !moveReq.write && moveOk)
				moveReadData <= next_moveReadData;
		end
	end

	// ------------------------------------------------------------------
	// table instruction answer and fault cause report
	// ------------------------------------------------------------------
	// the cause bit follows tableFault for one cycle; this block rewrites it
	// every cycle, so it is set only in the cycle after a refused instruction
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tableGo     <= 1'b0;
			tableFault  <= 1'b0;
			faultReport <= 64'h0000_0000_0000_0000;
		end else begin
			tableGo    <= tableReq.valid && opGranted;
			tableFault <= tableReq.valid && !opGranted;
			faultReport <= 64'h0000_0000_0000_0000;
			faultReport[`FAULT_CAUSE_BIT] <=
				tableReq.valid && !opGranted;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	nozero_blocks_a: assert property (
		tableReq.valid && permCode[tableReq.tableIdx] ==
			table_ctrl_pkg::PERM_NONE |=> tableFault && !tableGo)
		else $error("table op passed with permission zero");
	readonly_code_a: assert property (
		tableReq.valid && tableReq.op != table_ctrl_pkg::OP_READ &&
		permCode[tableReq.tableIdx] == table_ctrl_pkg::PERM_READ
		|=> tableFault)
		else $error("write op passed with read-only permission");
	update_nomovewr_a: assert property (
		moveReq.valid && moveReq.write && moveIsCfg &&
		permCode[moveTable] == table_ctrl_pkg::PERM_UPDATE
		|=> moveFault && !moveDone)
		else $error("register write passed with code two");
	full_allows_a: assert property (
		tableReq.valid && permCode[tableReq.tableIdx] ==
			table_ctrl_pkg::PERM_FULL |=> tableGo && !tableFault)
		else $error("op refused with full permission");
	fault_cause_a: assert property (
		tableFault |-> faultReport[`FAULT_CAUSE_BIT])
		else $error("fault cause bit missing");
	user_perm_a: assert property (
		moveReq.valid && moveReq.write && moveIsPerm &&
		!moveReq.supervisor |=> moveFault ##0 $stable(permCode[0]))
		else $error("user changed permission");
	base_low_a: assert property (
		$past(moveReq.valid && !moveReq.write && moveIsBase && moveOk)
		|-> moveReadData[6:0] == 7'h00)
		else $error("base low bits not zero");
	cfg_legal_a: assert property (
		cfgWord[0][`CFG_INTERP_HI] == 1'b0 &&
		cfgWord[0][`CFG_ELEM_HI:`CFG_ELEM_LO] <= `ELEM_CODE_MAX)
		else $error("illegal code stored");
	parallel_table_count_gap_a: assert property (
		cfgWord[1][`CFG_PARALLEL_TABLE_COUNT_HI:`CFG_PARALLEL_TABLE_COUNT_LO] != `PARALLEL_TABLE_COUNT_CODE_GAP)
		else $error("table count code three stored");
	size_weight_a: assert property (
		cfgWord[2][`CFG_SIZE_HI:`CFG_SIZE_LO] <= `SIZE_CODE_MAX &&
		cfgWord[2][`CFG_WEIGHT_HI:`CFG_WEIGHT_LO] <= `WEIGHT_CODE_MAX)
		else $error("reserved size or weight code stored");

	// ------------------------------------------------------------------
	// move path effects on the stored words
	// ------------------------------------------------------------------
	// a software move must never reach the read-only fields, otherwise
	// the bank layout could change under a running table instruction
	ro_fields_held_a: assert property (
		moveReq.valid && moveReq.write &&
		moveReq.index == `TBL_IDX_CFG0 && !roCfgWrite
		|=> cfgWord[0][`CFG_LEGACY_BIT:`CFG_WEIGHT_LO] ==
			$past(cfgWord[0][`CFG_LEGACY_BIT:`CFG_WEIGHT_LO]))
		else $error("move altered a read-only field");
	ro_load_a: assert property (
		roCfgWrite && roCfgTable == 2'h1
		|=> cfgWord[1][`CFG_LEGACY_BIT] ==
			$past(roCfgData[`CFG_LEGACY_BIT]) &&
		cfgWord[1][`CFG_WIDEN_HI:`CFG_WIDEN_LO] ==
			$past(roCfgData[`CFG_WIDEN_HI:`CFG_WIDEN_LO]))
		else $error("internal load lost a read-only field");
	clamp_signed_a: assert property (
		moveReq.valid && moveReq.write && moveOk &&
		moveReq.index == `TBL_IDX_CFG0 && !roCfgWrite
		|=> cfgWord[0][`CFG_CLAMP_BIT:`CFG_SIGNED_BIT] ==
			$past(moveReq.data[`CFG_CLAMP_BIT:`CFG_SIGNED_BIT]))
		else $error("clamp or signed bit not written");
	cfg_read_a: assert property (
		moveReq.valid && !moveReq.write && moveIsCfg && moveOk
		|=> moveDone && moveReadData == $past(cfgWord[moveTable]))
		else $error("configuration read returned wrong word");
	perm_write_a: assert property (
		moveReq.valid && moveReq.write && moveIsPerm && moveReq.supervisor
		|=> moveDone && permCode[1] ==
			$past(moveReq.data[`PERM_STRIDE+1:`PERM_STRIDE]))
		else $error("supervisor permission write lost");
	answer_onehot_a: assert property (
		!(moveDone && moveFault) && !(tableGo && tableFault))
		else $error("grant and fault raised together");

	move_grant_c: cover property (moveReq.valid ##1 moveDone);
	move_fault_c: cover property (moveReq.valid ##1 moveFault);
	op_fault_c:   cover property (tableReq.valid ##1 tableFault);
	op_go_c:      cover property (tableReq.valid ##1 tableGo);
	perm_write_c: cover property (moveIsPerm && moveReq.valid ##1 moveDone);

endmodule

// ### table_perm_check.sv
// Purpose: grant or refuse one access against a table permission code
// Assumes: purely combinational
// Notes:   shared by the move path and the instruction path
`timescale 1ns/1ps
module table_perm_check (
	input  wire table_ctrl_pkg::perm_code_t code,
	input  wire logic                       isMove,
	input  wire logic                       moveWrite,
	input  wire table_ctrl_pkg::table_op_t  op,
	output logic                            granted
);

	// ------------------------------------------------------------------
	// permission decode
	// ------------------------------------------------------------------
	// code 1 refuses register writes on every table alike, so the
	// four permission fields decode the same way
	always_comb begin
		granted = 1'b0;
		case (code)
			table_ctrl_pkg::PERM_NONE:
				granted = 1'b0;
			table_ctrl_pkg::PERM_READ:
				granted = isMove ? !moveWrite
					: (op == table_ctrl_pkg::OP_READ);
			table_ctrl_pkg::PERM_UPDATE:
				granted = isMove ? !moveWrite : 1'b1;
			table_ctrl_pkg::PERM_FULL:
				granted = 1'b1;
			default:
				granted = 1'b0;
		endcase
	end

endmodule

// ### test_lookup_table_config_and_permission.sv
// Purpose: self-checking bench for the table control registers
// Assumes: answers come one cycle after the request edge
// Notes:   a reference model predicts every answer and every decode
`timescale 1ns/1ps
module test_lookup_table_config_and_permission;
	logic clk, reset_n, ro, eDone, eMf, eGo, eTf, rKnown;
	logic moveDone, moveFault, tableGo, tableFault, roCfgWrite;
	logic [1:0] roT, roCfgTable;
	logic [63:0] roD, roCfgData, moveReadData, faultReport, eRead;
	table_ctrl_pkg::move_req_t mr, moveReq;
	table_ctrl_pkg::table_req_t tr, tableReq;
	table_ctrl_pkg::table_cfg_t cfgOut [4];
	logic [63:0] base [4];
	logic [63:0] cfg [4];
	logic [1:0] perm [4];
	bit bKnown [4];
	int badCount, comparisons;

	lookup_pipeline_model pm (.clk(clk), .moveReq(moveReq),
		.tableReq(tableReq), .roCfgTable(roCfgTable),
		.roCfgWrite(roCfgWrite), .roCfgData(roCfgData));
	table_ctrl_regs #(.TABLES(4)) dut (.clk(clk), .reset_n(reset_n),
		.moveReq(moveReq), .tableReq(tableReq), .roCfgTable(roCfgTable),
		.roCfgWrite(roCfgWrite), .roCfgData(roCfgData),
		.moveDone(moveDone), .moveReadData(moveReadData),
		.moveFault(moveFault), .tableGo(tableGo), .tableFault(tableFault),
		.faultReport(faultReport), .tableCfg(cfgOut));

	// ------------------------------------------------------------------
	// clock and helpers
	// ------------------------------------------------------------------
	// 20 MHz core clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic reportAndStop();
		$display("counts: %0d compared, %0d mismatched", comparisons, badCount);
		if (badCount == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input bit ok, input string msg);
		comparisons++;
		if (!ok) begin
			badCount++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	// unused bits drop and reserved codes of each field clear to zero
	function automatic logic [63:0] legal(input logic [63:0] w);
		logic [63:0] r;
		r = w & 64'h0000_0000_13FF_3FFF;
		if (w[23:16] > 8'h06) r[23:16] = 8'h00;
		if (w[13:11] > 3'h1) r[13:11] = 3'h0;
		if (w[10:8] > 3'h3) r[10:8] = 3'h0;
		if (w[5:3] > 3'h2) r[5:3] = 3'h0;
		if (w[2:0] == 3'h3 || w[2:0] > 3'h5) r[2:0] = 3'h0;
		return r;
	endfunction

	// fresh payloads every cycle, so stale values never look right
	task automatic rnd();
		mr = table_ctrl_pkg::move_req_t'({1'b0, 2'($urandom), 4'($urandom),
			$urandom, $urandom});
		tr.valid = 1'b0;
		tr.op = table_ctrl_pkg::table_op_t'(3'($urandom % 5));
		tr.tableIdx = 2'($urandom);
		ro = 1'b0;
		roT = 2'($urandom);
		roD = {$urandom, $urandom};
	endtask

	task automatic mv(input int i, input bit w, input bit s);
		mr.valid = 1'b1;
		mr.index = 4'(i);
		mr.write = w;
		mr.supervisor = s;
	endtask

	task automatic top(input int op, input int t);
		tr.valid = 1'b1;
		tr.op = table_ctrl_pkg::table_op_t'(3'(op));
		tr.tableIdx = 2'(t);
	endtask

	// ------------------------------------------------------------------
	// reference model
	// ------------------------------------------------------------------
	task automatic check();
		chk(moveDone === eDone && moveFault === eMf, "move answer");
		chk(tableGo === eGo && tableFault === eTf, "table answer");
		chk(faultReport === (eTf ? 64'h40 : 64'h0), "fault cause");
		if (rKnown)
			chk(moveReadData === eRead, "read data");
		for (int t = 0; t < 4; t++)
			chk(cfgOut[t] === table_ctrl_pkg::table_cfg_t'({cfg[t][28],
				cfg[t][25:16], cfg[t][13:0]}), "config decode");
	endtask

	task automatic predict();
		logic [1:0] p, mt;
		logic [63:0] pw;
		p = perm[tr.tableIdx];
		mt = mr.index[1:0];
		pw = 64'h0;
		for (int k = 0; k < 4; k++)
			pw[4*k+:2] = perm[k];
		eGo = tr.valid && p != 2'h0 && (p != 2'h1 || tr.op == 3'h0);
		eTf = tr.valid && !eGo;
		eDone = 1'b0;
		if (mr.index < 8)
			eDone = mr.write ? perm[mt] == 2'h3 : perm[mt] != 2'h0;
		else
			eDone = mr.index == 8 && (!mr.write || mr.supervisor);
		eDone = eDone && mr.valid;
		eMf = mr.valid && !eDone;
		if (eDone && !mr.write) begin
			rKnown = mr.index >= 4 || bKnown[mt];
			eRead = mr.index == 8 ? pw : mr.index < 4 ? base[mt] : cfg[mt];
		end
		if (eDone && mr.write) begin
			if (mr.index < 4) begin
				base[mt] = mr.data & 64'h0000_0000_0000_FF80;
				bKnown[mt] = 1'b1;
			end else if (mr.index < 8)
				cfg[mt] = (cfg[mt] & ~64'h7FF) | (legal(mr.data) & 64'h7FF);
			else
				for (int k = 0; k < 4; k++)
					perm[k] = mr.data[4*k+:2];
		end
		if (ro)
			cfg[roT] = legal(roD);
	endtask

	// drive at the edge, check the previous request once it settled
	task automatic step();
		@(posedge clk);
		pm.issue(mr, tr, ro, roT, roD);
		#1;
		check();
		predict();
		rnd();
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	initial begin
		#1_000_000;
		badCount++;
		reportAndStop();
	end

	initial begin
		reset_n = 1'b0;
		eDone = 1'b0;
		eMf = 1'b0;
		eGo = 1'b0;
		eTf = 1'b0;
		rKnown = 1'b1;
		eRead = 64'h0;
		for (int t = 0; t < 4; t++) begin
			cfg[t] = 64'h0;
			perm[t] = 2'h0;
			bKnown[t] = 1'b0;
		end
		void'($urandom(32'hd1db));
		rnd();
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		mv(8, 0, 0);
		step();
		for (int t = 0; t < 4; t++) begin
			mv(4 + t, 0, 1);
			top(0, t);
			step();
		end
		$display("test reset state done");
		mv(8, 1, 0);
		mr.data = '1;
		step();
		for (int c = 0; c < 4; c++) begin
			mv(8, 1, 1);
			for (int t = 0; t < 4; t++)
				mr.data[4*t+:2] = 2'((c + t) % 4);
			step();
			for (int t = 0; t < 4; t++)
				for (int k = 0; k < 5; k++) begin
					mv((k % 2) ? 4 + t : t, k >= 2, 0);
					top(k, t);
					step();
				end
		end
		$display("test permission sweep done");
		for (int i = 9; i < 16; i++) begin
			mv(i, i % 2, 1);
			step();
		end
		mv(8, 1, 1);
		mr.data = 64'h3333;
		step();
		for (int t = 0; t < 4; t++) begin
			mv(4 + t, 1, 1);
			ro = 1'b1;
			roT = 2'(t);
			step();
		end
		$display("test loads and unmapped done");
		for (int n = 0; n < 600; n++) begin
			mr.valid = 1'($urandom);
			tr.valid = 1'($urandom);
			ro = ($urandom % 4) == 0;
			step();
		end
		$display("test random traffic done");
		step();
		reportAndStop();
	end
endmodule
